/* File: hdl/spm_consts.svh */
// Constants for the serial peripheral master: offsets, reset values, timing
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

`define SPM_BASE_ADDR 16'h8000
`define SPM_TX_OFS 16'h008A
`define SPM_RX_OFS 16'h008E
`define SPM_EDGES_PER_BYTE 5'h10
`define SPM_DONE_EDGE 5'h0E
`define SPM_SS_IDLE 8'hFF
`define SPM_BYTE_RST 8'h00
`define SPM_FIFO_DEPTH 2'h2

`endif

/* File: hdl/spm_pkg.sv */
// Types for the serial peripheral master
package spm_pkg;
	typedef enum logic [1:0] {
		SPM_IDLE,
		SPM_LEAD,
		SPM_SHIFT
	} spm_state_e;
endpackage

/* File: hdl/spm_top.sv */
// Serial peripheral master: byte bus, two-entry receive buffer and serial engine
`timescale 1ns/1ps
`include "spm_consts.svh"
module spm_top (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input wire logic CE,
	// Host byte bus
	input wire logic [7:0] ADDR_HI,
	input wire logic [7:0] AD_IN,
	output logic [7:0] AD_OUT,
	output logic AD_OE,
	input wire logic ALE_N,
	input wire logic RD_N,
	input wire logic WR_N,
	input wire logic CODE_FETCH_STROBE_N,
	// Control inputs
	input wire logic START,
	input wire logic CLOCK_POLARITY,
	input wire logic CLOCK_PHASE,
	input wire logic [1:0] CLK_DIV_SEL,
	input wire logic INT_ENABLE,
	input wire logic [7:0] SLAVE_SEL,
	input wire logic ERR_CLEAR,
	// Status outputs
	output logic DONE,
	output logic BUS_ERROR,
	output logic TX_HOLDING_VACANT,
	output logic RX_HOLDING_LOADED,
	output logic INT_N,
	// Serial link
	output logic SCK,
	output logic MOSI,
	input wire logic MISO,
	output logic [7:0] SS_N,
	output logic SPI_OE,
	input wire logic SS_IN_N
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	logic [5:0] prev_q;
	logic ale_n_s, rd_n_s, wr_n_s, fetch_n_s, miso_s, ssin_n_s;

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sync1_q <= 6'h3F;
			sync2_q <= 6'h3F;
			prev_q <= 6'h3F;
		end else if (CE) begin
			sync1_q <= {ALE_N, RD_N, WR_N, CODE_FETCH_STROBE_N, MISO, SS_IN_N};
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	assign {ale_n_s, rd_n_s, wr_n_s, fetch_n_s, miso_s, ssin_n_s} = sync2_q;
	logic ale_fall, wr_fall, rd_rise;
	assign ale_fall = prev_q[5] & ~ale_n_s;
	assign wr_fall = prev_q[3] & ~wr_n_s;
	assign rd_rise = ~prev_q[4] & rd_n_s;
	logic contention;
	assign contention = ~ssin_n_s;

	////////////////////////////////////////////////////////////////////////////////
	// Host address latch and decode
	logic [15:0] addr_q;
	logic fetch_q;

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			addr_q <= 16'h0000;
			fetch_q <= 1'b0;
		end else if (CE && ale_fall) begin
			addr_q <= {ADDR_HI, AD_IN};
			fetch_q <= ~fetch_n_s;
		end
	end

	logic hit_tx, hit_rx;
	assign hit_tx = !fetch_q && addr_q == `SPM_BASE_ADDR + `SPM_TX_OFS;
	assign hit_rx = !fetch_q && addr_q == `SPM_BASE_ADDR + `SPM_RX_OFS;

	////////////////////////////////////////////////////////////////////////////////
	// Transmit holding register
	logic [7:0] tx_holding_reg_q;
	logic tx_full_q;
	logic load;

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tx_holding_reg_q <= `SPM_BYTE_RST;
			tx_full_q <= 1'b0;
		end else if (CE) begin
			if (load || contention)
				tx_full_q <= 1'b0;
			// A write in the same cycle as a move wins
			if (wr_fall && hit_tx) begin
				tx_holding_reg_q <= AD_IN;
				tx_full_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Two-entry receive buffer; head is the receive holding register
	logic [7:0] fifo_mem_q [0:1];
	logic wr_ptr_q, rd_ptr_q;
	logic [1:0] count_q;
	logic push, pop;
	logic [7:0] rx_sh_q;
	assign pop = rd_rise && hit_rx && count_q != 2'h0;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_entry
			always_ff @(posedge REF_CLK or negedge ARST_N) begin
				if (!ARST_N)
					fifo_mem_q[gi] <= `SPM_BYTE_RST;
				else if (CE && push && wr_ptr_q == 1'(gi))
					fifo_mem_q[gi] <= rx_sh_q;
			end
		end
	endgenerate

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= 2'h0;
		end else if (CE) begin
			if (push)
				wr_ptr_q <= ~wr_ptr_q;
			if (pop)
				rd_ptr_q <= ~rd_ptr_q;
			if (push && !pop)
				count_q <= count_q + 2'h1;
			else if (pop && !push)
				count_q <= count_q - 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Host read path
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			AD_OUT <= `SPM_BYTE_RST;
			AD_OE <= 1'b0;
		end else if (CE) begin
			AD_OE <= !rd_n_s && hit_rx;
			AD_OUT <= fifo_mem_q[rd_ptr_q];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial engine
	spm_pkg::spm_state_e state_q;
	logic [3:0] div_cnt_q;
	logic [4:0] edge_q;
	logic [7:0] tx_sh_q;
	// Byte finished, waiting for its last late sample
	logic end_q;
	// MISO sample strobes delayed by the synchroniser depth
	logic [1:0] samp_q;
	logic [3:0] half_len;
	logic tick;
	assign half_len = 4'(4'h1 << CLK_DIV_SEL);
	assign tick = div_cnt_q == half_len - 4'h1;
	// Starting needs buffer room so the finished byte is never dropped
	assign load = state_q == spm_pkg::SPM_IDLE && START && tx_full_q
		&& count_q != `SPM_FIFO_DEPTH && !contention && !BUS_ERROR;
	logic leading;
	assign leading = ~edge_q[0];
	assign push = state_q == spm_pkg::SPM_SHIFT && end_q && samp_q == 2'h0;

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= spm_pkg::SPM_IDLE;
			div_cnt_q <= 4'h0;
			edge_q <= 5'h00;
			tx_sh_q <= `SPM_BYTE_RST;
			rx_sh_q <= `SPM_BYTE_RST;
			SCK <= 1'b0;
			MOSI <= 1'b0;
			SS_N <= `SPM_SS_IDLE;
			DONE <= 1'b1;
			end_q <= 1'b0;
			samp_q <= 2'h0;
		end else if (CE) begin
			if (contention) begin
				state_q <= spm_pkg::SPM_IDLE;
				end_q <= 1'b0;
				samp_q <= 2'h0;
				SS_N <= `SPM_SS_IDLE;
				SCK <= CLOCK_POLARITY;
				edge_q <= 5'h00;
				div_cnt_q <= 4'h0;
			end else begin
				div_cnt_q <= (state_q == spm_pkg::SPM_IDLE || tick) ? 4'h0 : div_cnt_q + 4'h1;
				samp_q <= {samp_q[0], 1'b0};
				// The synced MISO now shows the level it had at the sampling edge
				if (samp_q[1])
					rx_sh_q <= {rx_sh_q[6:0], miso_s};
				case (state_q)
					spm_pkg::SPM_IDLE: begin
						SCK <= CLOCK_POLARITY;
						SS_N <= `SPM_SS_IDLE;
						if (load) begin
							tx_sh_q <= tx_holding_reg_q;
							MOSI <= tx_holding_reg_q[7];
							SS_N <= ~SLAVE_SEL;
							DONE <= 1'b0;
							edge_q <= 5'h00;
							state_q <= spm_pkg::SPM_LEAD;
						end
					end
					spm_pkg::SPM_LEAD: begin
						// Half a period here, so select leads the first edge by a full period
						if (tick)
							state_q <= spm_pkg::SPM_SHIFT;
					end
					spm_pkg::SPM_SHIFT: begin
						if (end_q) begin
							// Hand over only once the last late sample is in
							if (samp_q == 2'h0) begin
								// Select drops between bytes, as phase zero needs
								end_q <= 1'b0;
								state_q <= spm_pkg::SPM_IDLE;
								SS_N <= `SPM_SS_IDLE;
							end
						end else if (tick) begin
							if (edge_q == `SPM_EDGES_PER_BYTE) begin
								end_q <= 1'b1;
							end else begin
								SCK <= ~SCK;
								edge_q <= edge_q + 5'h01;
								if (edge_q == `SPM_DONE_EDGE)
									DONE <= 1'b1;
								if (leading == CLOCK_PHASE) begin
									// Output edge
									if (CLOCK_PHASE)
										MOSI <= tx_sh_q[7];
									else
										MOSI <= tx_sh_q[6];
									tx_sh_q <= {tx_sh_q[6:0], 1'b0};
								end else begin
									// Read two clocks later, past the synchroniser
									samp_q[0] <= 1'b1;
								end
							end
						end
					end
					default: state_q <= spm_pkg::SPM_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status, error and interrupt
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			BUS_ERROR <= 1'b0;
			SPI_OE <= 1'b0;
			TX_HOLDING_VACANT <= 1'b1;
			RX_HOLDING_LOADED <= 1'b0;
			INT_N <= 1'b1;
		end else if (CE) begin
			if (contention)
				BUS_ERROR <= 1'b1;
			else if (ERR_CLEAR)
				BUS_ERROR <= 1'b0;
			// Drivers released while another master owns the bus
			SPI_OE <= !contention && !BUS_ERROR;
			TX_HOLDING_VACANT <= ~tx_full_q;
			RX_HOLDING_LOADED <= count_q != 2'h0;
			INT_N <= ~(INT_ENABLE && (BUS_ERROR || contention
				|| (~tx_full_q && START)
				|| (count_q != 2'h0 && !START)));
		end
	end

endmodule // spm_top

/* File: tb/spm_slave.sv */
// Behavioural serial slave on select line 0
`timescale 1ns/1ps
module spm_slave (
	// Link
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic clock_phase,
	// Byte to return and byte taken
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx
);
	int n = 0;
	logic [7:0] sh = 8'h00;
	initial miso = 1'b0;
	// Released line flips, so a stale bit can never pass as data
	always @(posedge ss_n) miso = ~miso;
	always @(negedge ss_n) begin
		n = 0;
		sh = tx;
		miso = tx[7];
	end
	always @(sck) begin
		if (!ss_n) begin
			n++;
			if (n[0] ^ clock_phase) begin
				rx = {rx[6:0], mosi};
			end else if (clock_phase) begin
				miso = sh[7];
				sh = sh << 1;
			end else begin
				sh = sh << 1;
				miso = sh[7];
			end
		end
	end
endmodule // spm_slave

/* File: tb/spm_top_sva.sv */
// Port checks for the serial master
`timescale 1ns/1ps
module spm_top_chk (
	// Clock, reset, controls
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input wire logic START,
	input wire logic CLOCK_POLARITY,
	input wire logic [1:0] CLK_DIV_SEL,
	input wire logic INT_ENABLE,
	input wire logic [7:0] SLAVE_SEL,
	input wire logic SS_IN_N,
	// Status and link
	input wire logic DONE,
	input wire logic BUS_ERROR,
	input wire logic TX_HOLDING_VACANT,
	input wire logic RX_HOLDING_LOADED,
	input wire logic INT_N,
	input wire logic SCK,
	input wire logic [7:0] SS_N,
	input wire logic SPI_OE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_load;
		$past(SS_N) == 8'hFF && SS_N != 8'hFF;
	endsequence
	sequence s_end;
		$past(SS_N) != 8'hFF && SS_N == 8'hFF;
	endsequence
	property p_sel; s_load |-> SS_N == ~SLAVE_SEL && !DONE; endproperty
	a_sel: assert property (p_sel) else $error("bad select");
	property p_vac; s_load |=> TX_HOLDING_VACANT; endproperty
	a_vac: assert property (p_vac) else $error("no vacant");
	property p_gap; SS_N != 8'hFF && $changed(SS_N) |-> $past(SS_N) == 8'hFF; endproperty
	a_gap: assert property (p_gap) else $error("no gap");
	property p_rx; s_end ##0 !BUS_ERROR |=> RX_HOLDING_LOADED; endproperty
	a_rx: assert property (p_rx) else $error("no loaded");
	property p_done; $rose(DONE) && !BUS_ERROR |-> SS_N != 8'hFF; endproperty
	a_done: assert property (p_done) else $error("late done");
	property p_idle;
		(SS_N == 8'hFF && $stable(CLOCK_POLARITY)) [*2] |-> SCK == CLOCK_POLARITY;
	endproperty
	a_idle: assert property (p_idle) else $error("sck idle");
	property p_div;
		$changed(SCK) && SS_N != 8'hFF && CLK_DIV_SEL == 2'h3 |=> $stable(SCK) [*7];
	endproperty
	a_div: assert property (p_div) else $error("sck rate");
	property p_err;
		!SS_IN_N [*3] |=> ##[0:2] (BUS_ERROR && SS_N == 8'hFF && !SPI_OE);
	endproperty
	a_err: assert property (p_err) else $error("no abort");
	property p_ie; INT_ENABLE && BUS_ERROR |=> !INT_N; endproperty
	a_ie: assert property (p_ie) else $error("err int");
	property p_off; !INT_ENABLE |=> INT_N; endproperty
	a_off: assert property (p_off) else $error("masked int");
	property p_txi; $past(INT_ENABLE && START) && TX_HOLDING_VACANT |-> !INT_N; endproperty
	a_txi: assert property (p_txi) else $error("tx int");
	property p_rxi; $past(INT_ENABLE && !START) && RX_HOLDING_LOADED |-> !INT_N; endproperty
	a_rxi: assert property (p_rxi) else $error("rx int");
endmodule // spm_top_chk
bind spm_top spm_top_chk u_chk (.REF_CLK, .ARST_N, .START, .CLOCK_POLARITY, .CLK_DIV_SEL,
	.INT_ENABLE, .SLAVE_SEL, .SS_IN_N, .DONE, .BUS_ERROR, .TX_HOLDING_VACANT,
	.RX_HOLDING_LOADED, .INT_N, .SCK, .SS_N, .SPI_OE);

/* File: tb/tb.sv */
// Self-checking bench for the serial master
`timescale 1ns/1ps
module tb;
	logic REF_CLK = 0, ARST_N = 0, ALE_N = 1, RD_N = 1, WR_N = 1, START = 0;
	logic pol = 0, pha = 0, ie = 0, ssin = 1, clr = 0, oe, done, berr, vac, ldd, int_n;
	logic sck, mosi, miso, soe, psen = 1;
	logic [1:0] div = 0;
	logic [7:0] ahi = 0, adin = 0, sel = 1, stx = 0, rdq, srx, ado, ss;
	int mismatches = 0, n_checks = 0, cyc = 0;
	initial forever #10 REF_CLK = ~REF_CLK;
	spm_top uut (.REF_CLK, .ARST_N, .CE(1'b1), .ADDR_HI(ahi), .AD_IN(adin), .AD_OUT(ado),
		.AD_OE(oe), .ALE_N, .RD_N, .WR_N, .CODE_FETCH_STROBE_N(psen), .START,
		.CLOCK_POLARITY(pol), .CLOCK_PHASE(pha), .CLK_DIV_SEL(div), .INT_ENABLE(ie),
		.SLAVE_SEL(sel), .ERR_CLEAR(clr), .DONE(done), .BUS_ERROR(berr),
		.TX_HOLDING_VACANT(vac), .RX_HOLDING_LOADED(ldd), .INT_N(int_n), .SCK(sck),
		.MOSI(mosi), .MISO(miso), .SS_N(ss), .SPI_OE(soe), .SS_IN_N(ssin));
	spm_slave u_slv (.sck, .ss_n(ss[0]), .mosi, .clock_phase(pha), .tx(stx), .miso, .rx(srx));
	////////////////////////////////////////////////////////////////
	task automatic cy(int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	// Read and write strobes held 5 clocks, ALE_N 15: the host side passes through a 2-stage sync
	task automatic bus(logic [15:0] a, logic [7:0] d, logic rd);
		ALE_N = 0;
		{ahi, adin} = a;
		cy(5);
		adin = d;
		RD_N = !rd;
		WR_N = rd;
		cy(5);
		if (rd) chk("oe", 1, oe);
		rdq = ado;
		RD_N = 1;
		WR_N = 1;
		cy(5);
		ALE_N = 1;
		cy(2);
	endtask
	task automatic t_reset();
		cy(2);
		chk("ss", 8'hFF, ss);
		chk("flags", 8'h15, {done, berr, vac, ldd, int_n});
		ARST_N = 1;
		cy(3);
		bus(16'h8084, 8'h11, 0);
		chk("vac", 1, vac);
		psen = 0;
		bus(16'h808A, 8'h22, 0);
		psen = 1;
		chk("fetch", 1, vac);
		$display("test reset done");
	endtask
	task automatic t_xfer(logic [1:0] i);
		logic [7:0] t;
		t = 8'hB4 ^ i;
		{pha, pol} = i;
		div = i;
		sel = 8'h01 | (8'h10 << i);
		stx = ~t;
		ie = 1;
		bus(16'h808A, t, 0);
		START = 1;
		for (int k = 0; k < 50 && !vac; k++) cy(1);
		cy(1);
		chk("int", 0, int_n);
		START = 0;
		for (int k = 0; k < 400 && !ldd; k++) cy(1);
		cy(1);
		chk("int", 0, int_n);
		chk("done", 1, done);
		chk("slave", t, srx);
		bus(16'h808E, 0, 1);
		chk("rx", ~t, rdq);
		chk("ldd", 0, ldd);
		chk("int", 1, int_n);
		ie = 0;
		$display("test xfer %0d done", i);
	endtask
	task automatic t_buf();
		stx = 8'h5A;
		div = 0;
		START = 1;
		repeat (3) begin
			bus(16'h808A, 8'h3C, 0);
			for (int k = 0; k < 100 && !vac; k++) cy(1);
		end
		chk("vac", 0, vac);
		chk("ss", 8'hFF, ss);
		repeat (2) begin
			bus(16'h808E, 0, 1);
			chk("rx", 8'h5A, rdq);
		end
		START = 0;
		cy(60);
		bus(16'h808E, 0, 1);
		chk("rx", 8'h5A, rdq);
		chk("ldd", 0, ldd);
		$display("test buffer done");
	endtask
	task automatic t_err();
		div = 0;
		START = 1;
		bus(16'h808A, 8'h77, 0);
		ssin = 0;
		cy(5);
		chk("err", 8'hFF, {berr, ss[6:0]});
		chk("soe", 0, soe);
		ie = 1;
		cy(2);
		chk("int", 0, int_n);
		ssin = 1;
		START = 0;
		ie = 0;
		cy(4);
		clr = 1;
		cy(1);
		clr = 0;
		cy(2);
		chk("clr", 8'h03, {berr, soe, vac});
		$display("test contention done");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		t_reset();
		for (int i = 0; i < 4; i++) t_xfer(i[1:0]);
		t_buf();
		t_err();
		final_report();
	end
endmodule // tb
